// ===== hw/vcwd_cfg.svh
// Register indices, field positions and reset values of the capture window block
`ifndef VCWD_CFG_SVH
`define VCWD_CFG_SVH

`define VCWD_IDX_FORMAT 8'h51
`define VCWD_IDX_HCOEF 8'h52
`define VCWD_IDX_VCOEF 8'h53
`define VCWD_IDX_HSTART 8'h54
`define VCWD_IDX_HWIDTH 8'h55
`define VCWD_IDX_VSTART 8'h56
`define VCWD_IDX_EXT 8'h58
`define VCWD_IDX_STATUS 8'h5A

`define VCWD_REG_RESET 8'h00

`define VCWD_FMT_SEL_LSB 0
`define VCWD_FMT_SEL_MSB 2
`define VCWD_FMT_OPEN_BIT 3
`define VCWD_FMT_DSEN_BIT 4

`define VCWD_EXT_HSTART_LSB 0
`define VCWD_EXT_HSTART_MSB 1
`define VCWD_EXT_HWIDTH_LSB 2
`define VCWD_EXT_HWIDTH_MSB 3
`define VCWD_EXT_VSTART_BIT 4

`define VCWD_FMT_YUV422 3'h0
`define VCWD_FMT_RGB555 3'h1
`define VCWD_FMT_PRECOMP 3'h2
`define VCWD_FMT_YUV_COMP 3'h3

`define VCWD_LINE_CNT_MAX 9'h1FF

`endif

// ===== hw/vcwd_pkg.sv
// Types shared by the capture window block
package vcwd_pkg;

    typedef struct packed {
        logic line_ref;
        logic vsync;
        logic [15:0] data;
    } vcwd_pins_type;

    typedef struct packed {
        logic [9:0] hstart;
        logic [9:0] hwidth;
        logic [8:0] vstart;
        logic [7:0] hcoef;
        logic [7:0] vcoef;
    } vcwd_window_type;

    typedef enum logic [2:0] {
        VCWD_H_IDLE = 3'b001,
        VCWD_H_SKIP = 3'b010,
        VCWD_H_CAPT = 3'b100
    } vcwd_hstate_type;

endpackage

// ===== hw/vcwd_decim.sv
// Fractional decimator: drops one step each time the accumulator overflows
`timescale 1ns/100ps
module vcwd_decim
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Control
    input wire logic restart,
    input wire logic step,
    input wire logic [7:0] coef,
    // Decision for the current step
    output logic keep
);

    logic [7:0] acc_q;
    logic [7:0] acc_d;
    logic [8:0] sum;
    logic [7:0] base;

    // Coefficient/256 of the steps overflow and are dropped; zero never drops
    // A step in the restart cycle starts from zero, so the first item is judged fresh
    assign base = restart ? 8'h00 : acc_q;
    assign sum = {1'b0, base} + {1'b0, coef};
    assign keep = ~sum[8];
    assign acc_d = step ? sum[7:0] : base;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            acc_q <= 8'h00;
        end
        else
        begin
            acc_q <= acc_d;
        end
    end

endmodule

// ===== hw/vcwd_top.sv
// Capture window selection and pixel/scanline decimation of the video input port
//
// Summary of operation
// - Drop pixels at rate horizontal coefficient/256
// - Zero horizontal coefficient means no pixel drops
// - Drop scanlines at rate vertical coefficient/256
// - Zero vertical coefficient passes every scanline
// - Horizontal start is ten bits, extension 1:0
// - Horizontal start counts input pixels before decimation
// - Horizontal width is ten bits, extension 3:2
// - Width counts kept pixels after the start
// - Zero width captures while line reference high
// - Vertical start is nine bits, extension 4
// - After vsync fall count line pulses first
// - Start n skips exactly n full pulses
// - Vertical skip counts lines before decimation
// - Downscale only when enabled and format eligible
// - Operation enable changes at vsync falling edge
`timescale 1ns/100ps
module vcwd_top
(
    // Clock and reset
    input wire logic MCLK,
    input wire logic RSTN,
    // Indexed register port
    input wire logic [7:0] REG_INDEX,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    // Video decoder pins
    input wire logic PIX_CLK,
    input wire logic LINE_REF_IN,
    input wire logic VERTICAL_SYNC_IN,
    input wire logic [15:0] PIX_DATA,
    input wire logic CONFIG_SELECT_PIN,
    // Captured pixel stream
    output logic CAP_VALID,
    output logic [15:0] CAP_DATA,
    output logic CAP_LINE_START,
    output logic CAP_ACTIVE
);

`include "vcwd_cfg.svh"

    // ********************************************************
    // Register file
    // ********************************************************
    logic [7:0] format_control_q;
    logic [7:0] hcoef_q;
    logic [7:0] vcoef_q;
    logic [7:0] hstart_low_q;
    logic [7:0] hwidth_low_q;
    logic [7:0] vstart_low_q;
    logic [7:0] window_ext_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [7:0] status_word;

    wire wr_format = REG_WR && (REG_INDEX == `VCWD_IDX_FORMAT);
    wire wr_hcoef = REG_WR && (REG_INDEX == `VCWD_IDX_HCOEF);
    wire wr_vcoef = REG_WR && (REG_INDEX == `VCWD_IDX_VCOEF);
    wire wr_hstart = REG_WR && (REG_INDEX == `VCWD_IDX_HSTART);
    wire wr_hwidth = REG_WR && (REG_INDEX == `VCWD_IDX_HWIDTH);
    wire wr_vstart = REG_WR && (REG_INDEX == `VCWD_IDX_VSTART);
    wire wr_ext = REG_WR && (REG_INDEX == `VCWD_IDX_EXT);

    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            format_control_q <= `VCWD_REG_RESET;
            hcoef_q <= `VCWD_REG_RESET;
            vcoef_q <= `VCWD_REG_RESET;
            hstart_low_q <= `VCWD_REG_RESET;
            hwidth_low_q <= `VCWD_REG_RESET;
            vstart_low_q <= `VCWD_REG_RESET;
            window_ext_q <= `VCWD_REG_RESET;
        end
        else
        begin
            if (wr_format) format_control_q <= REG_WDATA;
            if (wr_hcoef) hcoef_q <= REG_WDATA;
            if (wr_vcoef) vcoef_q <= REG_WDATA;
            if (wr_hstart) hstart_low_q <= REG_WDATA;
            if (wr_hwidth) hwidth_low_q <= REG_WDATA;
            if (wr_vstart) vstart_low_q <= REG_WDATA;
            if (wr_ext) window_ext_q <= REG_WDATA;
        end
    end

    always_comb
    begin
        case (REG_INDEX)
            `VCWD_IDX_FORMAT: rdata_d = format_control_q;
            `VCWD_IDX_HCOEF: rdata_d = hcoef_q;
            `VCWD_IDX_VCOEF: rdata_d = vcoef_q;
            `VCWD_IDX_HSTART: rdata_d = hstart_low_q;
            `VCWD_IDX_HWIDTH: rdata_d = hwidth_low_q;
            `VCWD_IDX_VSTART: rdata_d = vstart_low_q;
            `VCWD_IDX_EXT: rdata_d = window_ext_q;
            `VCWD_IDX_STATUS: rdata_d = status_word;
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            rdata_q <= 8'h00;
        end
        else if (REG_RD)
        begin
            rdata_q <= rdata_d;
        end
    end

    assign REG_RDATA = rdata_q;

    // ********************************************************
    // Window fields
    // ********************************************************
    vcwd_pkg::vcwd_window_type win;

    assign win.hstart = {window_ext_q[`VCWD_EXT_HSTART_MSB:`VCWD_EXT_HSTART_LSB], hstart_low_q};
    assign win.hwidth = {window_ext_q[`VCWD_EXT_HWIDTH_MSB:`VCWD_EXT_HWIDTH_LSB], hwidth_low_q};
    assign win.vstart = {window_ext_q[`VCWD_EXT_VSTART_BIT], vstart_low_q};

    wire [2:0] fmt_sel = format_control_q[`VCWD_FMT_SEL_MSB:`VCWD_FMT_SEL_LSB];
    wire fmt_scalable = (fmt_sel == `VCWD_FMT_YUV422) || (fmt_sel == `VCWD_FMT_RGB555)
        || (fmt_sel == `VCWD_FMT_YUV_COMP);
    wire scale_on = format_control_q[`VCWD_FMT_DSEN_BIT] && fmt_scalable;

    // Coefficients forced to zero disable the decimators
    assign win.hcoef = scale_on ? hcoef_q : 8'h00;
    assign win.vcoef = scale_on ? vcoef_q : 8'h00;

    // ********************************************************
    // Pin synchronisers
    // ********************************************************
    vcwd_pkg::vcwd_pins_type pins_meta_q;
    vcwd_pkg::vcwd_pins_type pins_q;
    vcwd_pkg::vcwd_pins_type pins_prev_q;
    logic [2:0] pclk_sync_q;
    logic [1:0] cfg_sync_q;

    // Data is sampled one MCLK after the pixel clock edge has passed both stages
    wire pclk_rise = pclk_sync_q[1] && !pclk_sync_q[2];
    wire port_selected = !cfg_sync_q[1];
    wire line_rise = pclk_rise && pins_q.line_ref && !pins_prev_q.line_ref;
    wire line_fall = pclk_rise && !pins_q.line_ref && pins_prev_q.line_ref;
    wire vsync_fall = pclk_rise && !pins_q.vsync && pins_prev_q.vsync;
    wire pix_tick = pclk_rise && pins_q.line_ref;

    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            pins_meta_q <= '0;
            pins_q <= '0;
            pins_prev_q <= '0;
            pclk_sync_q <= 3'h0;
            cfg_sync_q <= 2'h3;
        end
        else
        begin
            pins_meta_q <= {LINE_REF_IN, VERTICAL_SYNC_IN, PIX_DATA};
            pins_q <= pins_meta_q;
            pclk_sync_q <= {pclk_sync_q[1:0], PIX_CLK};
            cfg_sync_q <= {cfg_sync_q[0], CONFIG_SELECT_PIN};
            if (pclk_rise)
            begin
                pins_prev_q <= pins_q;
            end
        end
    end

    // ********************************************************
    // Operation enable and vertical window
    // ********************************************************
    logic op_active_q;
    logic [8:0] line_cnt_q;
    logic [8:0] line_cnt_d;
    logic line_in_win_q;
    logic line_kept_q;

    // Enable is only sampled at field start so a register write never cuts a field in half
    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            op_active_q <= 1'b0;
        end
        else if (vsync_fall)
        begin
            op_active_q <= format_control_q[`VCWD_FMT_OPEN_BIT];
        end
    end

    // Counts complete line pulses, dropped or not, since the field began
    assign line_cnt_d = vsync_fall ? 9'h000
        : ((line_fall && line_cnt_q != `VCWD_LINE_CNT_MAX) ? line_cnt_q + 9'h001 : line_cnt_q);

    wire line_in_win_now = line_cnt_q >= win.vstart;
    wire vdec_keep;

    vcwd_decim u_vdec
    (
        .clk(MCLK),
        .rstn(RSTN),
        .restart(vsync_fall),
        .step(line_rise && line_in_win_now),
        .coef(win.vcoef),
        .keep(vdec_keep)
    );

    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            line_cnt_q <= 9'h000;
            line_in_win_q <= 1'b0;
            line_kept_q <= 1'b0;
        end
        else
        begin
            line_cnt_q <= line_cnt_d;
            if (vsync_fall)
            begin
                line_in_win_q <= 1'b0;
                line_kept_q <= 1'b0;
            end
            else if (line_rise)
            begin
                line_in_win_q <= line_in_win_now;
                line_kept_q <= line_in_win_now && vdec_keep;
            end
        end
    end

    // ********************************************************
    // Horizontal window
    // ********************************************************
    vcwd_pkg::vcwd_hstate_type hstate_q;
    vcwd_pkg::vcwd_hstate_type hstate_d;
    logic [9:0] in_cnt_q;
    logic [9:0] out_cnt_q;
    logic cap_valid_q;
    logic [15:0] cap_data_q;
    logic cap_first_q;
    logic first_pending_q;

    wire port_on = op_active_q && port_selected;
    wire hdec_keep;
    wire line_go = line_rise && port_on && line_in_win_now && vdec_keep;
    // The pixel that raises the line reference is index zero, so start zero keeps it
    wire [9:0] pix_idx = line_rise ? 10'h000 : in_cnt_q;
    wire [9:0] out_idx = line_rise ? 10'h000 : out_cnt_q;
    wire at_start = pix_idx >= win.hstart;
    wire width_done = (win.hwidth != 10'h000) && (out_idx == win.hwidth);
    wire in_line = line_rise ? line_go : (hstate_q != vcwd_pkg::VCWD_H_IDLE);
    wire take_pix = in_line && port_on && pix_tick && at_start && !width_done;
    wire emit_pix = take_pix && hdec_keep;

    vcwd_decim u_hdec
    (
        .clk(MCLK),
        .rstn(RSTN),
        .restart(line_rise),
        .step(take_pix),
        .coef(win.hcoef),
        .keep(hdec_keep)
    );

    always_comb
    begin
        hstate_d = hstate_q;
        case (hstate_q)
            vcwd_pkg::VCWD_H_IDLE:
            begin
                if (line_go && at_start)
                begin
                    hstate_d = vcwd_pkg::VCWD_H_CAPT;
                end
                else if (line_go)
                begin
                    hstate_d = vcwd_pkg::VCWD_H_SKIP;
                end
            end
            vcwd_pkg::VCWD_H_SKIP:
            begin
                if (!port_on || line_fall)
                begin
                    hstate_d = vcwd_pkg::VCWD_H_IDLE;
                end
                else if (at_start)
                begin
                    hstate_d = vcwd_pkg::VCWD_H_CAPT;
                end
            end
            vcwd_pkg::VCWD_H_CAPT:
            begin
                // Zero width runs until the line reference drops
                if (!port_on || line_fall || width_done)
                begin
                    hstate_d = vcwd_pkg::VCWD_H_IDLE;
                end
            end
            default:
            begin
                hstate_d = vcwd_pkg::VCWD_H_IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            hstate_q <= vcwd_pkg::VCWD_H_IDLE;
            in_cnt_q <= 10'h000;
            out_cnt_q <= 10'h000;
        end
        else
        begin
            hstate_q <= hstate_d;
            if (line_rise)
            begin
                in_cnt_q <= 10'h001;
                out_cnt_q <= {9'h000, emit_pix};
            end
            else
            begin
                if (pix_tick && !at_start)
                begin
                    in_cnt_q <= in_cnt_q + 10'h001;
                end
                if (emit_pix)
                begin
                    out_cnt_q <= out_cnt_q + 10'h001;
                end
            end
        end
    end

    // ********************************************************
    // Output stage
    // ********************************************************
    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            cap_valid_q <= 1'b0;
            cap_data_q <= 16'h0000;
            cap_first_q <= 1'b0;
            first_pending_q <= 1'b0;
        end
        else
        begin
            cap_valid_q <= emit_pix;
            cap_first_q <= emit_pix && (first_pending_q || line_rise);
            if (emit_pix)
            begin
                cap_data_q <= pins_q.data;
            end
            if (line_rise)
            begin
                first_pending_q <= !emit_pix;
            end
            else if (emit_pix)
            begin
                first_pending_q <= 1'b0;
            end
        end
    end

    assign CAP_VALID = cap_valid_q;
    assign CAP_DATA = cap_data_q;
    assign CAP_LINE_START = cap_first_q;
    assign CAP_ACTIVE = port_on;

    assign status_word = {4'h0, line_kept_q, line_in_win_q, hstate_q == vcwd_pkg::VCWD_H_CAPT, port_on};

endmodule

// ===== bench/vcwd_sva.sv
// Port-level assertions for the capture window block
`timescale 1ns/100ps
module vcwd_sva
(
    // Clock and reset
    input wire logic MCLK,
    input wire logic RSTN,
    // Register port
    input wire logic [7:0] REG_INDEX,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    // Decoder pins
    input wire logic PIX_CLK,
    input wire logic LINE_REF_IN,
    input wire logic VERTICAL_SYNC_IN,
    input wire logic [15:0] PIX_DATA,
    input wire logic CONFIG_SELECT_PIN,
    // Captured stream
    input wire logic CAP_VALID,
    input wire logic [15:0] CAP_DATA,
    input wire logic CAP_LINE_START,
    input wire logic CAP_ACTIVE
);
    // ****************
    // Quiet-time counters
    // ****************
    logic [5:0] quiet_q;
    logic [5:0] quiet_d;
    logic [5:0] lr_low_q;
    logic [5:0] lr_low_d;
    logic vs_q;
    logic pin_q;
    // Saturate at 63, well past the sync and edge-detect latency
    assign quiet_d = (VERTICAL_SYNC_IN != vs_q || CONFIG_SELECT_PIN != pin_q) ? 6'h00 : quiet_q + 6'(quiet_q != 6'h3F);
    assign lr_low_d = LINE_REF_IN ? 6'h00 : lr_low_q + 6'(lr_low_q != 6'h3F);
    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            quiet_q <= 6'h00;
            lr_low_q <= 6'h00;
            vs_q <= 1'b0;
            pin_q <= 1'b0;
        end
        else
        begin
            quiet_q <= quiet_d;
            lr_low_q <= lr_low_d;
            vs_q <= VERTICAL_SYNC_IN;
            pin_q <= CONFIG_SELECT_PIN;
        end
    end
    // ****************
    // Assertions
    // ****************
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RSTN);
    cap_needs_active_a: assert property (CAP_VALID |-> CAP_ACTIVE)
        else $error("capture outside an active field");
    valid_spacing_a: assert property (CAP_VALID |=> !CAP_VALID [*8])
        else $error("two captures within one input pixel");
    data_hold_a: assert property (!CAP_VALID |-> $stable(CAP_DATA))
        else $error("captured data changed without a capture");
    line_start_a: assert property (CAP_LINE_START |-> CAP_VALID)
        else $error("line start without a captured pixel");
    pin_off_a: assert property (CONFIG_SELECT_PIN [*4] |-> !CAP_ACTIVE)
        else $error("port active with config pin high");
    enable_change_a: assert property (quiet_q == 6'h3F |-> $stable(CAP_ACTIVE))
        else $error("active state changed inside a field");
    line_ref_bound_a: assert property (lr_low_q == 6'h3F |-> !CAP_VALID)
        else $error("capture long after line reference fell");
    start_readback_a: assert property ((REG_WR && REG_INDEX == 8'h54) ##1 (REG_RD && REG_INDEX == 8'h54) |=>
        REG_RDATA == $past(REG_WDATA, 2))
        else $error("start register read back wrong");
    line_cov: cover property (CAP_LINE_START);
    drop_cov: cover property ($fell(CAP_ACTIVE));
    rd_cov: cover property (REG_RD && REG_INDEX == 8'h40);
endmodule

bind vcwd_top vcwd_sva vcwd_sva_inst
(
    .MCLK, .RSTN, .REG_INDEX, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .PIX_CLK, .LINE_REF_IN,
    .VERTICAL_SYNC_IN, .PIX_DATA, .CONFIG_SELECT_PIN, .CAP_VALID, .CAP_DATA, .CAP_LINE_START, .CAP_ACTIVE
);

// ===== bench/vcwd_decoder_model.sv
// Behavioural video decoder: pixel clock, line reference, sync and data
`timescale 1ns/100ps
module vcwd_decoder_model
(
    // Pixel clock, still between fields
    output logic pix_clk,
    // Line reference, sync and pixel data
    output vcwd_pkg::vcwd_pins_type pins
);
    initial
    begin
        pix_clk = 1'b0;
        pins = '0;
    end

    task automatic tick(input int n);
        repeat (n)
        begin
            #80 pix_clk = 1'b1;
            #80 pix_clk = 1'b0;
        end
    endtask

    // Pixel word is line and pixel index, so any slip shows
    task automatic run_field(input int n_lines, input int n_pix);
        pins.vsync = 1'b1;
        tick(2);
        pins.vsync = 1'b0;
        tick(2);
        for (int l = 0; l < n_lines; l++)
        begin
            pins.line_ref = 1'b1;
            for (int i = 0; i < n_pix; i++)
            begin
                pins.data = {l[7:0], i[7:0]};
                tick(1);
            end
            pins.line_ref = 1'b0;
            // Blanked data must not look like the last pixel
            pins.data = ~pins.data;
            tick(3);
        end
        tick(2);
    endtask
endmodule

// ===== bench/tb_video_capture_window_downscale.sv
// Self-checking bench for the capture window and decimation block
`timescale 1ns/100ps
module tb_video_capture_window_downscale;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_index = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic config_pin = 1'b0;
    logic [7:0] reg_rdata;
    logic pix_clk;
    vcwd_pkg::vcwd_pins_type pins;
    logic cap_valid;
    logic [15:0] cap_data;
    logic cap_line_start;
    logic cap_active;
    logic [15:0] got_q[$];
    logic [15:0] exp_q[$];
    logic [7:0] fmt = 8'h00;
    logic [7:0] idx_list[8] = '{8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h58, 8'h5A};
    logic [7:0] fmt_list[4] = '{8'h08, 8'h19, 8'h1A, 8'h1B};
    int hc, vc, hs, hw, vs;
    int n_ls = 0;
    int err_total = 0;
    int n_tests = 0;

    vcwd_top vcwd_top_inst
    (
        .MCLK(mclk), .RSTN(rstn), .REG_INDEX(reg_index), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_RDATA(reg_rdata), .PIX_CLK(pix_clk), .LINE_REF_IN(pins.line_ref), .VERTICAL_SYNC_IN(pins.vsync),
        .PIX_DATA(pins.data), .CONFIG_SELECT_PIN(config_pin), .CAP_VALID(cap_valid), .CAP_DATA(cap_data),
        .CAP_LINE_START(cap_line_start), .CAP_ACTIVE(cap_active)
    );
    vcwd_decoder_model vcwd_decoder_model_inst
    (
        .pix_clk(pix_clk),
        .pins(pins)
    );

    always #5 mclk = ~mclk;

    always @(negedge mclk)
    begin
        if (cap_valid === 1'b1)
            got_q.push_back(cap_data);
        if (cap_line_start === 1'b1)
            n_ls++;
    end

    // ****************
    // Access and compare tasks
    // ****************
    task automatic check(input logic [15:0] got_v, input logic [15:0] exp_v);
        n_tests++;
        if (got_v !== exp_v)
        begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got_v, exp_v);
        end
    endtask

    task automatic access(input logic [7:0] idx, input logic [7:0] wd, input logic wr, input logic rd);
        reg_index = idx;
        reg_wdata = wd;
        reg_wr = wr;
        reg_rd = rd;
        @(negedge mclk);
    endtask

    task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
        access(idx, 8'h00, 1'b0, 1'b1);
        access(idx, 8'h00, 1'b0, 1'b0);
        check({8'h00, reg_rdata}, {8'h00, e});
    endtask

    task automatic cfg(input logic [7:0] f, input int h_c, input int v_c, input int h_s, input int h_w, input int v_s);
        fmt = f;
        hc = h_c;
        vc = v_c;
        hs = h_s;
        hw = h_w;
        vs = v_s;
        access(8'h51, f, 1'b1, 1'b0);
        access(8'h52, h_c[7:0], 1'b1, 1'b0);
        access(8'h53, v_c[7:0], 1'b1, 1'b0);
        access(8'h54, h_s[7:0], 1'b1, 1'b0);
        access(8'h55, h_w[7:0], 1'b1, 1'b0);
        access(8'h56, v_s[7:0], 1'b1, 1'b0);
        access(8'h58, {3'h0, v_s[8], h_w[9:8], h_s[9:8]}, 1'b1, 1'b0);
        access(8'h00, 8'h00, 1'b0, 1'b0);
    endtask

    // Expected stream: carry of the 8-bit accumulator drops the step
    task automatic run_chk(input int nl, input int np, input logic on);
        logic [8:0] va;
        logic [8:0] ha;
        int n;
        int ls;
        int hce;
        int vce;
        logic eff;
        eff = fmt[4] && (fmt[2:0] inside {3'h0, 3'h1, 3'h3});
        hce = eff ? hc : 0;
        vce = eff ? vc : 0;
        exp_q.delete();
        got_q.delete();
        n_ls = 0;
        ls = 0;
        va = '0;
        for (int l = 0; l < nl; l++)
        begin
            if (on && l >= vs)
            begin
                va = va[7:0] + vce;
                n = 0;
                ha = '0;
                for (int i = hs; i < np && (hw == 0 || n < hw) && !va[8]; i++)
                begin
                    ha = ha[7:0] + hce;
                    if (!ha[8])
                    begin
                        exp_q.push_back({l[7:0], i[7:0]});
                        n++;
                    end
                end
                ls += int'(n > 0);
            end
        end
        vcwd_decoder_model_inst.run_field(nl, np);
        repeat (40) @(negedge mclk);
        check(16'(got_q.size()), 16'(exp_q.size()));
        foreach (exp_q[k])
            if (k < got_q.size())
                check(got_q[k], exp_q[k]);
        check(16'(n_ls), 16'(ls));
        check({15'h0000, cap_active}, {15'h0000, on});
    endtask

    task automatic print_verdict;
        if (err_total == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ****************
    // Scenarios
    // ****************
    initial
    begin
        repeat (6) @(negedge mclk);
        rstn = 1'b1;
        foreach (idx_list[k])
            rchk(idx_list[k], 8'h00);
        access(8'h54, 8'hA6, 1'b1, 1'b0);
        rchk(8'h54, 8'hA6);
        access(8'h58, 8'h1F, 1'b1, 1'b0);
        rchk(8'h58, 8'h1F);
        access(8'h40, 8'h5A, 1'b1, 1'b0);
        rchk(8'h40, 8'h00);
        run_chk(3, 6, 1'b0);
        cfg(8'h08, 0, 0, 0, 0, 0);
        run_chk(4, 10, 1'b1);
        cfg(8'h18, 8'h80, 8'h55, 2, 4, 1);
        run_chk(6, 14, 1'b1);
        foreach (fmt_list[k])
        begin
            cfg(fmt_list[k], 8'h40, 8'h80, 0, 0, 0);
            run_chk(4, 8, 1'b1);
        end
        cfg(8'h08, 0, 0, 258, 258, 0);
        run_chk(2, 262, 1'b1);
        cfg(8'h08, 0, 0, 0, 0, 257);
        run_chk(259, 2, 1'b1);
        // Disable lands mid-field; vertical start is still 257, so nothing is captured and CAP_ACTIVE must stay high to the end
        fork
            run_chk(4, 6, 1'b1);
            begin
                repeat (300) @(negedge mclk);
                access(8'h51, 8'h00, 1'b1, 1'b0);
                access(8'h00, 8'h00, 1'b0, 1'b0);
            end
        join
        run_chk(2, 6, 1'b0);
        cfg(8'h08, 0, 0, 0, 0, 0);
        config_pin = 1'b1;
        run_chk(2, 6, 1'b0);
        config_pin = 1'b0;
        print_verdict;
    end

    initial
    begin
        repeat (90000) @(posedge mclk);
        err_total++;
        print_verdict;
    end
endmodule
